//--- mact_pkg.sv
package mact_pkg;

    // ***************************************************
    // Access lengths in machine cycles
    // ***************************************************
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RD_BASE_CYC = 4'h1;
    localparam logic [CNT_W-1:0] WR_BASE_CYC = 4'h2;
    localparam logic [CNT_W-1:0] WR_TURN_CYC = 4'h3;
    localparam logic [CNT_W-1:0] ONE_CYC = 4'h1;

    // ***************************************************
    // Single-access RAM map
    // ***************************************************
    localparam logic [15:0] SA_START = 16'h0800;
    localparam logic [15:0] LG_2K_END = 16'h2800;
    localparam logic [15:0] LG_1K_END = 16'h2C00;
    localparam logic [15:0] S1_1K_END = 16'h0C00;
    localparam logic [15:0] S2_2K_END = 16'h1000;
    localparam logic [15:0] S2_1K_END = 16'h1400;
    localparam int BLK_SHIFT = 11;
    localparam logic [2:0] LG_1K_BLK = 3'h4;
    localparam logic [2:0] S2_1K_BLK = 3'h1;

    // ***************************************************
    // Estimate width
    // ***************************************************
    localparam int EST_W = 24;
    localparam logic [EST_W-1:0] EST_ONE = 24'h000001;
    localparam logic [EST_W-1:0] EST_TWO = 24'h000002;

    // ***************************************************
    // Types
    // ***************************************************
    typedef enum logic [1:0] {MACT_LARGE, MACT_ONE_1K, MACT_2K_1K} mact_variant_e;
    typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_IO} mact_space_e;
    typedef enum logic [1:0] {F_ROM, F_DUAL_ACCESS_RAM, F_SINGLE_ACCESS_RAM, F_EXT} mact_fetch_e;
    typedef enum logic [1:0] {O_NONE, O_DUAL_ACCESS_RAM, O_SINGLE_ACCESS_RAM, O_EXT} mact_opnd_e;

    // External access request
    typedef struct packed {
        logic wr;
        mact_space_e space;
        logic [15:0] addr;
        logic [15:0] data;
    } mact_ext_req_s;

    // Software wait counts per space
    typedef struct packed {
        logic [CNT_W-1:0] prog;
        logic [CNT_W-1:0] data;
        logic [CNT_W-1:0] io;
    } mact_wait_s;

    // Common operand fields
    typedef struct packed {
        logic [6:0] dma;
        logic [2:0] aux_pointer_select;
        logic [3:0] shift;
    } mact_opfld_s;

    // Instruction description for cycle accounting
    typedef struct packed {
        mact_fetch_e fetch;
        mact_opnd_e opnd;
        logic repeat_single_op;
        logic [15:0] n;
        mact_opfld_s fld;
        logic same_section;
        logic discontinuity;
    } mact_instr_s;

endpackage : mact_pkg

//--- mact_sa_decode.sv
`timescale 1ns/10ps
// ***************************************************
// Single-access RAM block decoder
// ***************************************************
module mact_sa_decode (
    input wire mact_pkg::mact_variant_e variant,
    input wire logic [15:0] addr,
    output logic hit,
    output logic [2:0] blk
);
    import mact_pkg::*;

    // Offset from the first block, shifted to a 2K index
    wire logic [15:0] off = addr - SA_START;
    wire logic [2:0] idx2k = off[BLK_SHIFT+2:BLK_SHIFT];
    wire logic above = addr >= SA_START;

    // Range checks for each variant
    wire logic lg_2k = above && (addr < LG_2K_END);
    wire logic lg_1k = (addr >= LG_2K_END) && (addr < LG_1K_END);
    wire logic s1_1k = above && (addr < S1_1K_END);
    wire logic s2_2k = above && (addr < S2_2K_END);
    wire logic s2_1k = (addr >= S2_2K_END) && (addr < S2_1K_END);

    // Hit and block index select
    always_comb begin
        hit = 1'b0;
        blk = 3'h0;
        case (variant)
            MACT_LARGE: begin
                hit = lg_2k | lg_1k;
                blk = lg_1k ? LG_1K_BLK : idx2k;
            end
            MACT_ONE_1K: begin
                hit = s1_1k;
            end
            MACT_2K_1K: begin
                hit = s2_2k | s2_1k;
                blk = s2_1k ? S2_1K_BLK : 3'h0;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

endmodule : mact_sa_decode

//--- mact_top.sv
`timescale 1ns/10ps
module mact_top (
    input wire logic clk,
    input wire logic arst_n,
    // External access request, same clock
    input wire mact_pkg::mact_ext_req_s ext_req,
    input wire logic ext_req_valid,
    output logic ext_req_ready,
    input wire mact_pkg::mact_wait_s sw_wait,
    // External bus pins
    input wire logic ready_pin,
    output logic [15:0] ext_addr,
    output logic ext_strobe_n,
    output logic ext_rd_wr_n,
    output mact_pkg::mact_space_e ext_space,
    input wire logic [15:0] ext_data_in,
    output logic [15:0] ext_data_out,
    output logic ext_data_oe_n,
    // Completion
    output logic ext_done,
    output logic [15:0] rd_data,
    output logic [mact_pkg::CNT_W+3:0] last_cycles,
    // Single-access RAM arbitration
    input wire mact_pkg::mact_variant_e variant,
    input wire logic sa_a_req,
    input wire logic [15:0] sa_a_addr,
    input wire logic sa_b_req,
    input wire logic [15:0] sa_b_addr,
    output logic sa_a_grant,
    output logic sa_b_grant,
    output logic sa_stall,
    // Instruction cycle accounting
    input wire logic instr_valid,
    input wire mact_pkg::mact_instr_s instr,
    output logic [mact_pkg::EST_W-1:0] est_cycles,
    output logic est_valid,
    output logic est_exact,
    output mact_pkg::mact_opfld_s op_fields
);
    import mact_pkg::*;

    // ***************************************************
    // Reset release and pin synchronisers
    // ***************************************************
    logic rst_meta; // First reset stage
    logic rst_n; // Released reset used everywhere
    logic rdy_meta; // First ready stage, read only by rdy_s
    logic rdy_s; // Synchronised ready
    logic [15:0] din_meta; // First data stage
    logic [15:0] din_s; // Synchronised data

    // Reset asserts at once, releases after two edges
    // Release is clocked, so every flop leaves reset on the same edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pins come from outside, two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_meta <= 1'b1;
            rdy_s <= 1'b1;
            din_meta <= 16'h0000;
            din_s <= 16'h0000;
        end else begin
            rdy_meta <= ready_pin;
            rdy_s <= rdy_meta;
            din_meta <= ext_data_in;
            din_s <= din_meta;
        end
    end

    // ***************************************************
    // External access sequencer
    // ***************************************************
    typedef enum logic [2:0] {S_IDLE, S_ACCESS, S_RDY_WAIT, S_WR_TAIL, S_TURN} mact_state_e;
    mact_state_e state; // Current phase
    mact_state_e next_state; // Phase for next edge
    mact_ext_req_s cur; // Access in flight
    logic [CNT_W-1:0] cnt; // Remaining programmed cycles
    logic [CNT_W+3:0] cyc; // Cycles spent on this access
    logic prev_rd; // A read ended in the previous cycle
    logic stretched; // Write already lengthened by a neighbour read
    logic [CNT_W-1:0] m_sel; // Software waits for requested space
    logic [CNT_W-1:0] m_cur; // Software waits for access in flight
    logic [CNT_W-1:0] tgt; // Programmed length of new access

    // Waits are chosen by address space
    always_comb begin
        case (ext_req.space)
            SP_PROG: m_sel = sw_wait.prog;
            SP_DATA: m_sel = sw_wait.data;
            SP_IO: m_sel = sw_wait.io;
            default: m_sel = sw_wait.data;
        endcase
        case (cur.space)
            SP_PROG: m_cur = sw_wait.prog;
            SP_DATA: m_cur = sw_wait.data;
            SP_IO: m_cur = sw_wait.io;
            default: m_cur = sw_wait.data;
        endcase
    end

    // Base length; generator waits replace it when nonzero
    wire logic new_turn = ext_req.wr && prev_rd && (m_sel == '0);
    wire logic [CNT_W-1:0] base_len = !ext_req.wr ? RD_BASE_CYC : (prev_rd ? WR_TURN_CYC : WR_BASE_CYC);
    assign tgt = (m_sel != '0) ? m_sel + ONE_CYC : base_len;

    wire logic accept = ext_req_valid && ext_req_ready;
    wire logic cnt_done = (cnt == '0);
    // A read waiting right behind a zero-wait write not already stretched stretches that write
    wire logic rd_next = ext_req_valid && !ext_req.wr;
    wire logic need_turn = cur.wr && !stretched && rd_next && (m_cur == '0);

    // Sequencer decisions
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (accept) begin
                    next_state = S_ACCESS;
                end
            end
            S_ACCESS: begin
                if (!cnt_done) begin
                    next_state = S_ACCESS;
                end else if (!rdy_s) begin
                    next_state = S_RDY_WAIT;
                end else if (need_turn) begin
                    next_state = S_TURN;
                end else begin
                    next_state = S_IDLE;
                end
            end
            S_RDY_WAIT: begin
                // Writes held by ready need one more cycle
                if (rdy_s) begin
                    next_state = cur.wr ? S_WR_TAIL : S_IDLE;
                end
            end
            // Write data stays on the bus one cycle past ready
            S_WR_TAIL: begin
                next_state = S_IDLE;
            end
            // Extra cycle lets the bus turn before the queued read
            S_TURN: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // Finish marks the last cycle of any access
    wire logic finish = (state != S_IDLE) && (next_state == S_IDLE);

    // State and access registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cur <= '0;
            cnt <= '0;
            stretched <= 1'b0;
        end else begin
            state <= next_state;
            if (accept) begin
                cur <= ext_req;
                cnt <= tgt - ONE_CYC;
                stretched <= new_turn;
            end else if (state == S_ACCESS && !cnt_done) begin
                cnt <= cnt - ONE_CYC;
            end
        end
    end

    // Cycle count and read-adjacency tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc <= '0;
            prev_rd <= 1'b0;
            last_cycles <= '0;
        end else begin
            cyc <= accept ? {{4{1'b0}}, ONE_CYC} : cyc + {{(CNT_W+3){1'b0}}, 1'b1};
            if (finish) begin
                last_cycles <= cyc;
            end
            // Only a read ending this cycle counts as adjacent
            prev_rd <= finish && !cur.wr;
        end
    end

    // Read data and completion pulse
    // Limitation: a read of one or two cycles returns pin data from before its strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
            ext_done <= 1'b0;
        end else begin
            ext_done <= finish;
            if (finish && !cur.wr) begin
                rd_data <= din_s;
            end
        end
    end

    // Bus pins follow the access in flight; idle level is released
    wire logic busy = (state != S_IDLE);
    assign ext_req_ready = (state == S_IDLE);
    assign ext_addr = cur.addr;
    assign ext_space = cur.space;
    assign ext_strobe_n = !busy;
    assign ext_rd_wr_n = !(busy && cur.wr);
    assign ext_data_out = cur.data;
    // Driver is off in the turnaround cycle to avoid a bus clash
    assign ext_data_oe_n = !(busy && cur.wr && state != S_TURN);

    // ***************************************************
    // Single-access RAM arbitration
    // ***************************************************
    logic a_hit; // Port A in a single-access block
    logic b_hit; // Port B in a single-access block
    logic [2:0] a_blk; // Port A block index
    logic [2:0] b_blk; // Port B block index

    // One decoder per pipeline port
    mact_sa_decode u_dec_a (
        .variant(variant),
        .addr(sa_a_addr),
        .hit(a_hit),
        .blk(a_blk)
    );

    // Second port decoded the same way
    mact_sa_decode u_dec_b (
        .variant(variant),
        .addr(sa_b_addr),
        .hit(b_hit),
        .blk(b_blk)
    );

    // Different blocks run in parallel; same block clashes
    wire logic sa_clash = sa_a_req && sa_b_req && a_hit && b_hit && (a_blk == b_blk);
    // Port A always wins, so the first pipeline access never waits
    assign sa_a_grant = sa_a_req;
    // Port B loses and must re-present next cycle
    assign sa_b_grant = sa_b_req && !sa_clash;
    assign sa_stall = sa_clash;

    // ***************************************************
    // Instruction cycle accounting
    // ***************************************************
    wire logic [EST_W-1:0] p_w = {{(EST_W-CNT_W){1'b0}}, sw_wait.prog};
    wire logic [EST_W-1:0] d_w = {{(EST_W-CNT_W){1'b0}}, sw_wait.data};
    wire logic [EST_W-1:0] n_w = {{(EST_W-16){1'b0}}, instr.n};
    // Product formed at full estimate width so long repeats do not wrap
    wire logic [EST_W-1:0] nd_w = EST_W'(n_w * d_w);
    // Only an external fetch or operand changes the count
    wire logic f_ext = (instr.fetch == F_EXT);
    wire logic o_ext = (instr.opnd == O_EXT);
    logic [EST_W-1:0] next_est; // Estimate for the presented op

    // Fetch versus own operand is the only conflict charged
    always_comb begin
        if (!instr.repeat_single_op) begin
            if (o_ext) begin
                next_est = f_ext ? EST_TWO + d_w + p_w : EST_ONE + d_w;
            end else begin
                next_est = f_ext ? EST_ONE + p_w : EST_ONE;
            end
        end else begin
            if (o_ext) begin
                next_est = f_ext ? n_w + EST_ONE + p_w + nd_w : n_w + nd_w;
            end else begin
                next_est = f_ext ? n_w + p_w : n_w;
            end
        end
    end

    // Register the estimate and operand fields
    // Fields pass through unchanged; their ranges are fixed by their widths
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            est_cycles <= '0;
            est_valid <= 1'b0;
            est_exact <= 1'b0;
            op_fields <= '0;
        end else begin
            est_valid <= instr_valid;
            if (instr_valid) begin
                est_cycles <= next_est;
                est_exact <= instr.same_section || instr.discontinuity;
                op_fields <= instr.fld;
            end
        end
    end

endmodule : mact_top

//--- mact_monitor.sv
`timescale 1ns/10ps
// ***********************************
// Pin-level timing, arbitration and estimate checker
// ***********************************
module mact_monitor (
    input logic clk,
    input logic arst_n,
    input mact_pkg::mact_ext_req_s ext_req,
    input logic ext_req_valid,
    input logic ext_req_ready,
    input mact_pkg::mact_wait_s sw_wait,
    input logic ready_pin,
    input logic ext_strobe_n,
    input logic ext_done,
    input logic [mact_pkg::CNT_W+3:0] last_cycles,
    input mact_pkg::mact_variant_e variant,
    input logic sa_a_req,
    input logic [15:0] sa_a_addr,
    input logic sa_b_req,
    input logic [15:0] sa_b_addr,
    input logic sa_a_grant,
    input logic sa_b_grant,
    input logic sa_stall,
    input logic instr_valid,
    input mact_pkg::mact_instr_s instr,
    input logic [mact_pkg::EST_W-1:0] est_cycles,
    input logic est_valid,
    input logic est_exact,
    input mact_pkg::mact_opfld_s op_fields
);
    import mact_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic take = ext_req_valid && ext_req_ready; // Request accepted this edge
    wire logic [CNT_W-1:0] m_sel = (ext_req.space == SP_PROG) ? sw_wait.prog :
        (ext_req.space == SP_DATA) ? sw_wait.data : sw_wait.io; // Generator count of the offered space
    logic wr_q; // Access in flight is a write
    logic rlow; // Ready seen low, so the length is not fixed
    logic [CNT_W-1:0] m_q; // Generator count of the access in flight
    logic [7:0] scnt; // Strobe-low cycles since the take
    // Track the access in flight
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= 1'b0;
            rlow <= 1'b0;
            m_q <= '0;
            scnt <= 8'h00;
        end else if (take) begin
            wr_q <= ext_req.wr;
            rlow <= !ready_pin;
            m_q <= m_sel;
            scnt <= 8'h00;
        end else begin
            rlow <= rlow | !ready_pin;
            scnt <= scnt + {7'h00, !ext_strobe_n};
        end
    end
    // Ready quiet around the take; the sync lag makes older values matter
    sequence s_quiet_take;
        take && ready_pin && $past(ready_pin) && $past(ready_pin, 2);
    endsequence
    // A plain read: one strobe cycle, then completion
    sequence s_rd_one;
        !ext_strobe_n ##1 (ext_strobe_n && ext_done);
    endsequence
    AST_RD_ONE: assert property (s_quiet_take ##0 (!ext_req.wr && m_sel == '0) |=> s_rd_one)
        else $error("plain read not one cycle");
    AST_WR_TWO: assert property (s_quiet_take ##0 (ext_req.wr && m_sel == '0) |=> !ext_strobe_n [*2])
        else $error("plain write shorter than two cycles");
    AST_WR_LEN: assert property (ext_done && !rlow && m_q == '0 && wr_q |-> last_cycles inside {8'h02, 8'h03})
        else $error("plain write length wrong");
    AST_GEN_LEN: assert property (ext_done && !rlow && m_q != '0 |-> last_cycles == {4'h0, m_q} + 8'h01)
        else $error("generator wait length wrong");
    AST_STROBE_CNT: assert property (ext_done |-> scnt == last_cycles)
        else $error("strobe length differs from reported length");
    AST_SA_A: assert property (sa_a_req |-> sa_a_grant)
        else $error("first port refused");
    AST_SA_DIFF: assert property (sa_a_req && sa_b_req && sa_a_addr[15:11] != sa_b_addr[15:11]
        |-> sa_b_grant && !sa_stall)
        else $error("different blocks serialised");
    AST_SA_SAME: assert property (sa_a_req && sa_b_req && variant == MACT_LARGE
        && sa_a_addr inside {[16'h0800:16'h27FF]} && sa_a_addr[15:11] == sa_b_addr[15:11]
        |-> sa_stall && !sa_b_grant)
        else $error("same block not serialised");
    AST_EST_INT: assert property (instr_valid && instr.fetch != F_EXT && instr.opnd != O_EXT
        |=> est_valid && est_cycles == ($past(instr.repeat_single_op) ? {8'h00, $past(instr.n)} : EST_ONE))
        else $error("internal estimate wrong");
    AST_EST_FLD: assert property (instr_valid |=> op_fields == $past(instr.fld)
        && est_exact == $past(instr.same_section | instr.discontinuity))
        else $error("fields or exact flag wrong");
endmodule : mact_monitor

bind mact_top mact_monitor u_mon (.clk, .arst_n, .ext_req, .ext_req_valid, .ext_req_ready, .sw_wait,
    .ready_pin, .ext_strobe_n, .ext_done, .last_cycles, .variant, .sa_a_req, .sa_a_addr, .sa_b_req,
    .sa_b_addr, .sa_a_grant, .sa_b_grant, .sa_stall, .instr_valid, .instr, .est_cycles, .est_valid,
    .est_exact, .op_fields);

//--- mact_mem_model.sv
`timescale 1ns/10ps
// ***********************************
// External memory with slow ready
// ***********************************
module mact_mem_model (
    input logic clk,
    input logic arst_n,
    input logic [3:0] slow,
    input logic [15:0] ext_addr,
    input logic ext_strobe_n,
    input logic ext_rd_wr_n,
    input logic [15:0] ext_data_out,
    input logic ext_data_oe_n,
    output logic [15:0] ext_data_in,
    output logic ready_pin
);
    logic [15:0] mem [64]; // Small store, low address bits only
    logic [15:0] last; // Last pin value
    logic [3:0] cnt; // Cycles ready is still held low
    // Store a word only while the device drives the lines
    always_ff @(posedge clk) begin
        if (!ext_strobe_n && !ext_rd_wr_n && !ext_data_oe_n) begin
            mem[ext_addr[5:0]] <= ext_data_out;
        end
    end
    // Ready low between accesses and for slow cycles into each one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
            last <= 16'h0000;
        end else begin
            cnt <= ext_strobe_n ? slow : cnt - {3'h0, cnt != 4'h0};
            last <= ext_data_in;
        end
    end
    assign ready_pin = cnt == 4'h0;
    // Unselected bus never repeats its last value
    assign ext_data_in = (!ext_strobe_n && ext_rd_wr_n) ? mem[ext_addr[5:0]] : ~last;
endmodule : mact_mem_model

//--- tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t %h %h", $time, g, e); end end
module tb_top;
    import mact_pkg::*;
    // ***********************************
    // Signals, design and far side
    // ***********************************
    localparam int P = 2; // Program waits for the estimate
    localparam int D = 3; // Data waits for the estimate
    logic clk = 1'b0, arst_n = 1'b0, ext_req_valid = 1'b0, instr_valid = 1'b0, sa_a_req = 1'b0, sa_b_req = 1'b0;
    logic ext_req_ready, ready_pin, ext_strobe_n, ext_rd_wr_n, ext_data_oe_n, ext_done, ar, br, cl;
    logic sa_a_grant, sa_b_grant, sa_stall, est_valid, est_exact;
    logic [15:0] ext_addr, ext_data_in, ext_data_out, rd_data, a, b, rnd = 16'h0054;
    logic [15:0] sa_a_addr = 16'h0000, sa_b_addr = 16'h0000;
    logic [7:0] last_cycles, got, ex;
    logic [3:0] slow = 4'h0;
    logic [2:0] es;
    logic [38:0] ee;
    logic [EST_W-1:0] est_cycles;
    mact_ext_req_s ext_req = '0;
    mact_wait_s sw_wait = '0;
    mact_variant_e variant = MACT_LARGE;
    mact_space_e ext_space;
    mact_instr_s instr = '0;
    mact_opfld_s op_fields;
    int errors = 0, n_tests = 0, cyc = 0, n, c;
    logic [7:0] q_ext[$];
    logic [2:0] q_sa[$];
    logic [38:0] q_est[$];
    always #12.5 clk = ~clk;
    mact_top u_dut (.clk, .arst_n, .ext_req, .ext_req_valid, .ext_req_ready, .sw_wait, .ready_pin, .ext_addr,
        .ext_strobe_n, .ext_rd_wr_n, .ext_space, .ext_data_in, .ext_data_out, .ext_data_oe_n, .ext_done, .rd_data,
        .last_cycles, .variant, .sa_a_req, .sa_a_addr, .sa_b_req, .sa_b_addr, .sa_a_grant, .sa_b_grant, .sa_stall,
        .instr_valid, .instr, .est_cycles, .est_valid, .est_exact, .op_fields);
    mact_mem_model u_mem (.clk, .arst_n, .slow, .ext_addr, .ext_strobe_n, .ext_rd_wr_n, .ext_data_out,
        .ext_data_oe_n, .ext_data_in, .ready_pin);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Block number, -1 outside single-access RAM
    function automatic int blk(input int v, input logic [15:0] x);
        if (x < 16'h0800) return -1;
        if (v == 0) return (x < 16'h2C00) ? int'(x[15:11]) : -1;
        if (v == 1) return (x < 16'h0C00) ? 0 : -1;
        return (x < 16'h1000) ? 0 : (x < 16'h1400) ? 1 : -1;
    endfunction : blk
    // One access; valid drops only after the last of a burst
    task automatic acc(input logic w, input int sp, input logic [15:0] ad, input logic [15:0] d,
                       input logic [7:0] e, input bit lst);
        ext_req <= '{w, mact_space_e'(sp), ad, d};
        ext_req_valid <= 1'b1;
        q_ext.push_back(e);
        do @(posedge clk); while (ext_req_ready !== 1'b1);
        if (lst) ext_req_valid <= 1'b0;
    endtask : acc
    task automatic drain(input string m);
        while (q_ext.size() != 0) @(posedge clk);
        repeat (3) @(posedge clk);
        $display("test %s done", m);
    endtask : drain
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // ***********************************
    // Result watchers and hang limit
    // ***********************************
    always @(posedge clk) begin
        if (ext_done === 1'b1) begin
            got = last_cycles;
            ex = (q_ext.size() != 0) ? q_ext.pop_front() : 8'hFF;
            `CHK(last_cycles, ex)
        end
        if (est_valid === 1'b1) begin
            ee = q_est.pop_front();
            `CHK({est_cycles, est_exact, op_fields}, ee)
        end
        cyc++;
        if (cyc == 3000) begin
            errors++;
            final_report();
        end
    end
    always @(negedge clk) begin
        if (q_sa.size() != 0) begin
            es = q_sa.pop_front();
            `CHK({sa_a_grant, sa_b_grant, sa_stall}, es)
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, 1, 16'h0001, 16'h0000, 8'h01, 1'b1);
        repeat (3) @(posedge clk);
        acc(1'b1, 1, 16'h0002, rnd, 8'h02, 1'b0);
        // A write with a read queued behind it takes the turnaround cycle
        acc(1'b1, 1, 16'h0003, rnd, 8'h03, 1'b0);
        acc(1'b0, 1, 16'h0003, 16'h0000, 8'h01, 1'b1);
        drain("base");
        // Read, write, read back to back: the write stretches
        acc(1'b0, 2, 16'h0004, 16'h0000, 8'h01, 1'b0);
        acc(1'b1, 2, 16'h0005, rnd, 8'h03, 1'b0);
        acc(1'b0, 0, 16'h0006, 16'h0000, 8'h01, 1'b1);
        drain("turnaround");
        for (int s = 0; s < 3; s++) begin
            rnd = lfsr(rnd);
            sw_wait <= mact_wait_s'(12'(s + 2) << (4 * (2 - s)));
            @(posedge clk);
            acc(1'b1, s, 16'(s + 8), rnd, 8'(s + 3), 1'b0);
            acc(1'b0, s, 16'(s + 8), 16'h0000, 8'(s + 3), 1'b1);
            drain("wait states");
            `CHK(rd_data, rnd)
            `CHK(ext_space, mact_space_e'(s))
        end
        sw_wait <= '0;
        slow <= 4'h3;
        repeat (3) @(posedge clk);
        // Ready low three cycles into the access, seen two cycles late
        acc(1'b0, 1, 16'h0003, 16'h0000, 8'h06, 1'b1);
        drain("ready read");
        `CHK(got > 8'h01, 1'b1)
        acc(1'b1, 1, 16'h0003, rnd, 8'h07, 1'b1);
        drain("ready write");
        slow <= 4'h0;
        for (int v = 0; v < 3; v++) begin
            for (int i = 0; i < 40; i++) begin
                @(posedge clk);
                rnd = lfsr(rnd);
                a = {2'b00, rnd[13:0]};
                b = rnd[15] ? (a ^ 16'h0155) : {2'b00, rnd[6:0], rnd[13:7]};
                ar = rnd[14] | rnd[0];
                br = rnd[1] | rnd[2];
                cl = ar && br && blk(v, a) >= 0 && blk(v, a) == blk(v, b);
                variant <= mact_variant_e'(v);
                sa_a_req <= ar;
                sa_b_req <= br;
                sa_a_addr <= a;
                sa_b_addr <= b;
                q_sa.push_back({ar, br && !cl, cl});
            end
        end
        @(posedge clk);
        sa_a_req <= 1'b0;
        sa_b_req <= 1'b0;
        sw_wait <= '{4'(P), 4'(D), 4'h0};
        $display("test arbitration done");
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            rnd = lfsr(rnd);
            n = int'(rnd[3:0]) + 3;
            if (i[3:2] == 2'h3) c = i[4] ? (i[1:0] == 2'h3 ? n + 1 + P + n * D : n + n * D) : (i[1:0] == 2'h3 ? 2 + D + P : 1 + D);
            else c = i[4] ? (i[1:0] == 2'h3 ? n + P : n) : (i[1:0] == 2'h3 ? 1 + P : 1);
            instr <= '{mact_fetch_e'(i[1:0]), mact_opnd_e'(i[3:2]), i[4], 16'(n), mact_opfld_s'(rnd[13:0]), rnd[14], rnd[15]};
            instr_valid <= 1'b1;
            q_est.push_back({24'(c), rnd[14] | rnd[15], rnd[13:0]});
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge clk);
        $display("test estimate done");
        final_report();
    end
endmodule : tb_top
